// [hdl/tmc_event_detect.sv]
// Purpose: External edge and pulse length detector for the trigger connector
// Assumes: ext_level is synchronous to pclk; one pclk is one sample
// Notes:   Pulse modes decide at the edge that ends the pulse

module tmc_event_detect (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire tmc_pkg::tmc_cfg_t cfg,
  input  wire logic             ext_level,
  input  wire logic             arm,
  output logic                  hit
);

  logic       prev_reg;  // Level seen one sample ago
  logic [8:0] len_reg;   // Samples the current level has lasted
  logic       hit_reg;   // Registered detection pulse
  logic       hit_next;  // Detection for this sample
  logic       rise;      // Low to high change
  logic       fall;      // High to low change
  logic       longer;    // Ended level beat the threshold
  logic       shorter;   // Ended level fell short of it

  assign rise    = ext_level & ~prev_reg;
  assign fall    = ~ext_level & prev_reg;
  assign longer  = len_reg > {1'b0, cfg.width};
  assign shorter = len_reg < {1'b0, cfg.width};
  assign hit     = hit_reg;

  // Previous level for edge detection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= ext_level;

  // Length of the current level, saturating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      len_reg <= 9'h000;
    else if (rise || fall)
      len_reg <= 9'h001;
    else if (len_reg != 9'h1FF)
      len_reg <= len_reg + 9'h001;

  // Decode the selected condition
  always_comb
  begin
    case (cfg.mode)
      tmc_pkg::RISING_EDGE_CODE:      hit_next = rise;
      tmc_pkg::FALLING_EDGE_CODE:     hit_next = fall;
      tmc_pkg::EITHER_EDGE_CODE:      hit_next = rise | fall;
      tmc_pkg::LONG_HIGH_PULSE_CODE:  hit_next = fall & longer;
      tmc_pkg::SHORT_HIGH_PULSE_CODE: hit_next = fall & shorter;
      tmc_pkg::LONG_LOW_PULSE_CODE:   hit_next = rise & longer;
      tmc_pkg::SHORT_LOW_PULSE_CODE:  hit_next = rise & shorter;
      // Internal modes never hit here
      default:                        hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hit_reg <= 1'b0;
    else
      hit_reg <= arm & hit_next;

endmodule

// [hdl/tmc_pkg.sv]
// Purpose: Shared constants, types and helpers for the trigger mode control block
// Assumes: APB register access with 32-bit data, one word per register
// Notes:   Register positions are word indices; byte address is four times the index

package tmc_pkg;

  // Register word indices
  localparam logic [15:0] IDX_COMMAND     = 16'h0000;  // Command register
  localparam logic [15:0] IDX_SOURCE_SEL  = 16'h9C40;  // Trigger source select
  localparam logic [15:0] IDX_CONN_DIR    = 16'h9CA4;  // Connector direction
  localparam logic [15:0] IDX_TERMINATION = 16'h9CAE;  // Input termination
  localparam logic [15:0] IDX_PULSE_LEN   = 16'hABE0;  // Pulse length threshold
  localparam logic [15:0] IDX_STATUS      = 16'hA000;  // Block status, read only

  // Address width covering the highest byte address
  localparam int unsigned ADDR_W = 18;

  // Command codes
  localparam logic [31:0] CMD_START       = 32'h0000_0004;  // Arm the board
  localparam logic [31:0] CMD_STOP        = 32'h0000_0040;  // Abort and go idle
  localparam logic [31:0] FORCE_EVENT_CMD = 32'h0000_0010;  // Force a trigger event

  // Trigger mode codes
  localparam logic [31:0] FREE_RUN_CODE         = 32'h0000_0000;
  localparam logic [31:0] RISING_EDGE_CODE      = 32'h0000_4E20;
  localparam logic [31:0] FALLING_EDGE_CODE     = 32'h0000_4E2A;
  localparam logic [31:0] EITHER_EDGE_CODE      = 32'h0000_4E3E;
  localparam logic [31:0] LONG_HIGH_PULSE_CODE  = 32'h0000_4E21;
  localparam logic [31:0] SHORT_HIGH_PULSE_CODE = 32'h0000_4E22;
  localparam logic [31:0] LONG_LOW_PULSE_CODE   = 32'h0000_4E2B;
  localparam logic [31:0] SHORT_LOW_PULSE_CODE  = 32'h0000_4E2C;

  // Reset values
  localparam logic [31:0] RST_SOURCE_SEL = 32'h0000_0000;
  localparam logic [7:0]  RST_PULSE_LEN  = 8'h02;

  // Status field positions
  localparam int unsigned ST_STATE_LSB = 0;  // Four one-hot state bits
  localparam int unsigned ST_EXT_EN    = 4;  // External input path enabled
  localparam int unsigned ST_TRIGGERED = 5;  // Trigger taken since last start

  // Timing, clock 200 MHz
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SETUP_TIME_NS = 100;  // Internal setup before arming
  localparam int unsigned TRIG_OUT_NS   = 50;   // Least high time of trigger output
  localparam int unsigned SETUP_CYCLES  = (SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRIG_OUT_CYCLES = (TRIG_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Configuration handed to the detector
  typedef struct packed {
    logic [31:0] mode;   // Trigger source select value
    logic [7:0]  width;  // Pulse length threshold in samples
  } tmc_cfg_t;

  // True for any of the seven external modes
  function automatic logic tmc_is_ext(input logic [31:0] mode);
    tmc_is_ext = (mode == RISING_EDGE_CODE) || (mode == FALLING_EDGE_CODE) ||
                 (mode == EITHER_EDGE_CODE) || (mode == LONG_HIGH_PULSE_CODE) ||
                 (mode == SHORT_HIGH_PULSE_CODE) || (mode == LONG_LOW_PULSE_CODE) ||
                 (mode == SHORT_LOW_PULSE_CODE);
  endfunction

endpackage

// [hdl/tmc_top.sv]
// Function
// - Free-run code starts acquisition without waiting
// - Free-run begins after internal setup delay only
// - Force command triggers only while waiting
// - Direction zero leaves connector driver disabled
// - Direction one outputs internal trigger events
// - Trigger output active high at acquisition start
// - External mode codes enable input path
// - Decode rising, falling and both edge codes
// - Code selects long high pulse detection
// - Code selects short high pulse detection
// - Code selects long low pulse detection
// - Code selects short low pulse detection
// - External modes force connector to input
// - Termination one is low while an input, zero high impedance
// - One trigger per start until rearmed
// - Failing pulse comparison produces no trigger
//
// Purpose: Trigger source selection, connector control and arming for a digitizer
// Assumes: APB slave, 32-bit data, one pclk per sample, inputs synchronous
// Notes:   APB answers with pready in the second cycle of the access phase

module tmc_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       trig_conn_in,
  output logic                            trig_conn_out,
  output logic                            trig_conn_oe,
  output logic                            term_low_z,
  output logic                            ext_input_en,
  output logic                            acq_start,
  input  wire logic                       acq_done
);

  // Arming states, one-hot
  typedef enum logic [3:0] {
    TMC_IDLE  = 4'b0001,  // Stopped
    TMC_SETUP = 4'b0010,  // Internal setup after start
    TMC_WAIT  = 4'b0100,  // Armed, waiting for trigger
    TMC_RUN   = 4'b1000   // Recording in progress
  } tmc_state_t;

  tmc_state_t        state_reg;        // Current arming state
  tmc_state_t        state_next;       // Next arming state
  logic [31:0]       command_reg;      // Last command written
  logic [31:0]       source_sel_reg;   // Trigger source select
  logic              conn_dir_reg;     // Connector direction bit
  logic              termination_reg;  // Termination select bit
  logic [7:0]        pulse_len_reg;    // Pulse length threshold
  logic [7:0]        setup_cnt_reg;    // Setup delay counter
  logic [7:0]        out_cnt_reg;      // Trigger output hold counter
  logic              triggered_reg;    // Trigger taken since start
  logic [31:0]       prdata_reg;       // Read data
  logic              pready_reg;       // Transfer answer
  logic              pslverr_reg;      // Unmapped or read-only access flag
  logic              trig_out_reg;     // Connector output level
  logic              trig_oe_reg;      // Connector driver enable
  logic              term_reg;         // Termination output
  logic              ext_en_reg;       // External path enable
  logic              acq_start_reg;    // Acquisition start pulse
  logic              ext_mode;         // Source select is external
  logic              drive_conn;       // Connector driven from next cycle
  logic              ext_hit;          // External condition met
  logic              fire;             // Trigger taken this cycle
  logic              wr_take;          // Write takes effect
  logic              cmd_wr;           // Command register written
  logic              mapped;           // Address hits a register
  logic [15:0]       word_idx;         // Register index from address
  tmc_pkg::tmc_cfg_t det_cfg;          // Detector configuration

  assign word_idx = paddr[tmc_pkg::ADDR_W-1:2];
  assign ext_mode = tmc_pkg::tmc_is_ext(source_sel_reg);
  // Driver and termination follow one decision so they never overlap
  assign drive_conn = conn_dir_reg & ~ext_mode;
  assign wr_take  = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign cmd_wr   = wr_take && (word_idx == tmc_pkg::IDX_COMMAND);
  assign det_cfg  = '{mode: source_sel_reg, width: pulse_len_reg};

  // Outputs come straight from flip-flops
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign trig_conn_out = trig_out_reg;
  assign trig_conn_oe  = trig_oe_reg;
  assign term_low_z    = term_reg;
  assign ext_input_en  = ext_en_reg;
  assign acq_start     = acq_start_reg;

  // Address decode of mapped words
  always_comb
  begin
    case (word_idx)
      tmc_pkg::IDX_COMMAND,
      tmc_pkg::IDX_SOURCE_SEL,
      tmc_pkg::IDX_CONN_DIR,
      tmc_pkg::IDX_TERMINATION,
      tmc_pkg::IDX_PULSE_LEN,
      tmc_pkg::IDX_STATUS: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // External edge and pulse detector
  tmc_event_detect u_detect (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (det_cfg),
    .ext_level (trig_conn_in),
    // input path only in external modes
    .arm       (ext_mode && (state_reg == TMC_WAIT)),
    .hit       (ext_hit)
  );

  // Trigger decision while waiting
  always_comb
  begin
    fire = 1'b0;
    if (state_reg == TMC_WAIT)
    begin
      if (source_sel_reg == tmc_pkg::FREE_RUN_CODE)
        fire = 1'b1;
      else if (cmd_wr && (pwdata == tmc_pkg::FORCE_EVENT_CMD))
        fire = 1'b1;
      else if (ext_hit)
        fire = 1'b1;
    end
  end

  // APB answer: one extra access cycle, then pready
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pready_reg <= 1'b0;
    else
      pready_reg <= psel & penable & ~pready_reg;

  // Error flag for unmapped or read-only targets
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pslverr_reg <= 1'b0;
    else if (psel & penable & ~pready_reg)
      pslverr_reg <= ~mapped | (pwrite && (word_idx == tmc_pkg::IDX_STATUS));
    else
      pslverr_reg <= 1'b0;

  // Read data capture, zero on unmapped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (psel & penable & ~pready_reg & ~pwrite)
    begin
      case (word_idx)
        tmc_pkg::IDX_COMMAND:     prdata_reg <= command_reg;
        tmc_pkg::IDX_SOURCE_SEL:  prdata_reg <= source_sel_reg;
        tmc_pkg::IDX_CONN_DIR:    prdata_reg <= {31'h0000_0000, conn_dir_reg};
        tmc_pkg::IDX_TERMINATION: prdata_reg <= {31'h0000_0000, termination_reg};
        tmc_pkg::IDX_PULSE_LEN:   prdata_reg <= {24'h00_0000, pulse_len_reg};
        tmc_pkg::IDX_STATUS:
        begin
          prdata_reg <= 32'h0000_0000;
          prdata_reg[tmc_pkg::ST_STATE_LSB +: 4] <= state_reg;
          prdata_reg[tmc_pkg::ST_EXT_EN]         <= ext_en_reg;
          prdata_reg[tmc_pkg::ST_TRIGGERED]      <= triggered_reg;
        end
        default:                  prdata_reg <= 32'h0000_0000;
      endcase
    end

  // Command register holds the last code written
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      command_reg <= 32'h0000_0000;
    else if (cmd_wr)
      command_reg <= pwdata;

  // Trigger source select
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      source_sel_reg <= tmc_pkg::RST_SOURCE_SEL;
    else if (wr_take && (word_idx == tmc_pkg::IDX_SOURCE_SEL))
      source_sel_reg <= pwdata;

  // Connector direction bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      conn_dir_reg <= 1'b0;
    else if (wr_take && (word_idx == tmc_pkg::IDX_CONN_DIR))
      conn_dir_reg <= pwdata[0];

  // Termination select bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      termination_reg <= 1'b0;
    else if (wr_take && (word_idx == tmc_pkg::IDX_TERMINATION))
      termination_reg <= pwdata[0];

  // Pulse length threshold; range kept by software
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pulse_len_reg <= tmc_pkg::RST_PULSE_LEN;
    else if (wr_take && (word_idx == tmc_pkg::IDX_PULSE_LEN))
      pulse_len_reg <= pwdata[7:0];

  // Arming state transitions
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      // Start command leaves idle
      TMC_IDLE:
        if (cmd_wr && (pwdata == tmc_pkg::CMD_START))
          state_next = TMC_SETUP;
      // only the setup delay precedes arming
      TMC_SETUP:
        if (setup_cnt_reg == 8'h00)
          state_next = TMC_WAIT;
      // Waiting for the first qualifying event
      TMC_WAIT:
        if (fire)
          state_next = TMC_RUN;
      TMC_RUN:
        if (acq_done)
          state_next = TMC_IDLE;
      default:
        state_next = TMC_IDLE;
    endcase
    // Stop aborts from any state
    if (cmd_wr && (pwdata == tmc_pkg::CMD_STOP))
      state_next = TMC_IDLE;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      state_reg <= TMC_IDLE;
    else
      state_reg <= state_next;

  // Setup delay countdown
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      setup_cnt_reg <= 8'h00;
    else if (state_reg != TMC_SETUP)
      setup_cnt_reg <= 8'(tmc_pkg::SETUP_CYCLES - 1);
    else if (setup_cnt_reg != 8'h00)
      setup_cnt_reg <= setup_cnt_reg - 8'h01;

  // Triggered flag, cleared by a new start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      triggered_reg <= 1'b0;
    else if (fire)
      triggered_reg <= 1'b1;
    else if (state_reg == TMC_SETUP)
      triggered_reg <= 1'b0;

  // Acquisition start pulse, one cycle per trigger
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      acq_start_reg <= 1'b0;
    else
      acq_start_reg <= fire;

  // Trigger output hold counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      out_cnt_reg <= 8'h00;
    else if (fire)
      out_cnt_reg <= 8'(tmc_pkg::TRIG_OUT_CYCLES);
    else if (out_cnt_reg != 8'h00)
      out_cnt_reg <= out_cnt_reg - 8'h01;

  // Connector driver enable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trig_oe_reg <= 1'b0;
    else
      // drive only for internal modes with direction set
      trig_oe_reg <= drive_conn;

  // Connector output level
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trig_out_reg <= 1'b0;
    else
      // high from acquisition start; never re-rises mid hold
      trig_out_reg <= drive_conn & (fire | (trig_out_reg & (out_cnt_reg > 8'h01)));

  // External path enable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ext_en_reg <= 1'b0;
    else
      ext_en_reg <= ext_mode;

  // Termination select output
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      term_reg <= 1'b0;
    else
      // low impedance only while an input
      term_reg <= termination_reg & ~drive_conn;

endmodule

// [verif/tmc_assertions.sv]
// Purpose: Port-level assertions for the trigger mode control block
// Assumes: Single pclk domain, presetn asynchronous and active low
// Notes:   Bound to every tmc_top instance; watches design outputs other than prdata, plus the psel and penable inputs
module tmc_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trig_conn_out,
  input wire logic trig_conn_oe,
  input wire logic term_low_z,
  input wire logic ext_input_en,
  input wire logic acq_start
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks share the APB clock and reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ext_no_drive: assert property (ext_input_en |-> !trig_conn_oe)
    else $error("connector driven while an external mode is selected");
  a_term_drive: assert property (trig_conn_oe |-> !term_low_z)
    else $error("low impedance termination while driving");
  a_out_needs_oe: assert property (!trig_conn_oe |-> !trig_conn_out)
    else $error("trigger output high with driver disabled");
  a_out_marks_start: assert property ($rose(trig_conn_out) |-> acq_start)
    else $error("trigger output rose without acquisition start");
  a_out_ten_cycles: assert property ($rose(trig_conn_out) |-> trig_conn_out [*8] ##1 trig_conn_out [*2] ##1 !trig_conn_out)
    else $error("trigger output high time wrong");
  a_start_single: assert property (acq_start |=> !acq_start [*8])
    else $error("second acquisition start without rearm");
  // Ready in the second access cycle
  a_ready_timing: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  // Ready lasts one cycle
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // Error only with ready
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing transfer");

  // Main scenarios reached
  c_out_pulse: cover property ($rose(trig_conn_out));
  c_ext_start: cover property (ext_input_en && acq_start);
  c_refused: cover property (pslverr);
  c_low_z: cover property (ext_input_en && term_low_z);
endmodule

bind tmc_top tmc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .trig_conn_out(trig_conn_out), .trig_conn_oe(trig_conn_oe),
  .term_low_z(term_low_z), .ext_input_en(ext_input_en), .acq_start(acq_start));

// [verif/tmc_ttl_source.sv]
// Purpose: External TTL trigger source on the trigger connector
// Assumes: One pclk per sample; level changes just after a rising edge
// Notes:   Always drives; the bench lets the device driver win while enabled
module tmc_ttl_source (
  input  wire logic pclk,
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line starts low
  initial level = 1'b0;

  // Idle level between events
  task automatic idle(input logic v);
    level <= v;
  endtask

  task automatic pulse(input logic v, input int len);
    level <= v;
    repeat (len) @(posedge pclk);
    level <= ~v;
  endtask
endmodule

// [verif/trigger_mode_control_bench.sv]
// Purpose: Self-checking bench for the trigger mode control block
// Assumes: APB master and TTL source model, one pclk per sample
// Notes:   Expectations come from a register and trigger model kept here
module trigger_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                       acq_done = 1'b0, pready, pslverr, src_level, wire_level;
  logic [tmc_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0]                pwdata = '0, prdata, rd;
  logic                       trig_conn_out, trig_conn_oe, term_low_z, ext_input_en, acq_start;
  int                         err_count, checked, w, at, out_cnt;
  int unsigned                model_reg [int];  // Register model by word index
  // Modes: idle level and kind (0 edge at start, 1 edge at end, 2 long, 3 short)
  logic [31:0] mode_code [7] = '{tmc_pkg::RISING_EDGE_CODE, tmc_pkg::FALLING_EDGE_CODE,
    tmc_pkg::EITHER_EDGE_CODE, tmc_pkg::LONG_HIGH_PULSE_CODE, tmc_pkg::SHORT_HIGH_PULSE_CODE,
    tmc_pkg::LONG_LOW_PULSE_CODE, tmc_pkg::SHORT_LOW_PULSE_CODE};
  logic        mode_idle [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  int          mode_kind [7] = '{0, 1, 0, 2, 3, 2, 3};

  // Connector level: device driver wins while enabled
  assign wire_level = trig_conn_oe ? trig_conn_out : src_level;

  tmc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_conn_in(wire_level),
    .trig_conn_out(trig_conn_out), .trig_conn_oe(trig_conn_oe), .term_low_z(term_low_z),
    .ext_input_en(ext_input_en), .acq_start(acq_start), .acq_done(acq_done));
  tmc_ttl_source src (.pclk(pclk), .level(src_level));

  // 200 MHz clock
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  // Watchdog far beyond the expected run
  initial
  begin
    #200us;
    err_count++;
    final_report();
  end

  task automatic final_report();
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address map model: unmapped index or write to status is refused
  function automatic logic map_err(input logic wr, input logic [15:0] idx);
    map_err = !(idx inside {tmc_pkg::IDX_COMMAND, tmc_pkg::IDX_SOURCE_SEL, tmc_pkg::IDX_CONN_DIR,
      tmc_pkg::IDX_TERMINATION, tmc_pkg::IDX_PULSE_LEN, tmc_pkg::IDX_STATUS}) || (wr && idx == tmc_pkg::IDX_STATUS);
  endfunction

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk("pready pslverr", {pready, pslverr}, {1'b1, map_err(wr, idx)});
    psel    <= 1'b0;
    penable <= 1'b0;
    if (wr && !map_err(wr, idx))
      model_reg[idx] = (idx == tmc_pkg::IDX_PULSE_LEN) ? (wd & 32'h0000_00FF) : wd;
  endtask

  task automatic rreg(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk("read", rd & mask, exp);
  endtask

  // First acq_start cycle and output high time over a span
  task automatic watch(input int span);
    at = -1;
    out_cnt = 0;
    for (int i = 1; i <= span; i++)
    begin
      @(posedge pclk);
      if (acq_start === 1'b1 && at < 0)
        at = i;
      if (trig_conn_out === 1'b1)
        out_cnt++;
    end
  endtask

  // One source pulse; fire expected from the mode model
  task automatic stim(input int k, input int len, input logic armed);
    logic exp_fire;
    int   lo;
    exp_fire = armed && (mode_kind[k] < 2 || (mode_kind[k] == 2 && len > w) || (mode_kind[k] == 3 && len < w));
    lo = (mode_kind[k] == 0) ? 0 : len;
    fork
      src.pulse(!mode_idle[k], len);
      watch(len + 12);
    join
    chk("fired", at >= 0, exp_fire);
    if (exp_fire)
      chk("latency", at >= lo + 2 && at <= lo + 6, 1'b1);
  endtask

  task automatic finish_rec();
    @(posedge pclk);
    acq_done <= 1'b1;
    @(posedge pclk);
    acq_done <= 1'b0;
  endtask

  initial
  begin
    int len;
    void'($urandom(32'h9012A2E0));
    w = 4 + $urandom_range(16);
    model_reg[tmc_pkg::IDX_SOURCE_SEL] = tmc_pkg::RST_SOURCE_SEL;
    model_reg[tmc_pkg::IDX_PULSE_LEN]  = tmc_pkg::RST_PULSE_LEN;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("oe", trig_conn_oe, 1'b0);
    rreg(tmc_pkg::IDX_SOURCE_SEL, 32'hFFFF_FFFF, model_reg[tmc_pkg::IDX_SOURCE_SEL]);
    rreg(tmc_pkg::IDX_PULSE_LEN, 32'h0000_00FF, model_reg[tmc_pkg::IDX_PULSE_LEN]);
    rreg(tmc_pkg::IDX_STATUS, 32'h0000_003F, 32'h0000_0001);
    apb(1'b1, 16'h0001, $urandom());
    rreg(16'h0001, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, tmc_pkg::IDX_STATUS, 32'h0000_0000);
    // Free run with the connector as trigger output
    apb(1'b1, tmc_pkg::IDX_SOURCE_SEL, tmc_pkg::FREE_RUN_CODE);
    apb(1'b1, tmc_pkg::IDX_CONN_DIR, 32'h0000_0001);
    apb(1'b1, tmc_pkg::IDX_TERMINATION, 32'h0000_0001);
    chk("oe term", {trig_conn_oe, term_low_z}, 2'b10);
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_START);
    watch(tmc_pkg::SETUP_CYCLES + 20);
    chk("setup", at >= tmc_pkg::SETUP_CYCLES && at <= tmc_pkg::SETUP_CYCLES + 6, 1'b1);
    chk("out high", out_cnt, tmc_pkg::TRIG_OUT_CYCLES);
    rreg(tmc_pkg::IDX_STATUS, 32'h0000_003F, 32'h0000_0028);
    // bench board is of a revision that takes the force command
    // Force in run and in idle is dropped, force in wait fires
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::FORCE_EVENT_CMD);
    finish_rec();
    rreg(tmc_pkg::IDX_STATUS, 32'h0000_000F, 32'h0000_0001);
    apb(1'b1, tmc_pkg::IDX_SOURCE_SEL, 32'h0000_0001);
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::FORCE_EVENT_CMD);
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_START);
    watch(tmc_pkg::SETUP_CYCLES + 20);
    chk("queued", at, -1);
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::FORCE_EVENT_CMD);
    watch(8);
    chk("forced", at > 0 && at <= 4, 1'b1);
    chk("forced out", out_cnt > 0, 1'b1);
    finish_rec();
    // External modes with a random pulse threshold
    apb(1'b1, tmc_pkg::IDX_PULSE_LEN, w);
    rreg(tmc_pkg::IDX_PULSE_LEN, 32'h0000_00FF, model_reg[tmc_pkg::IDX_PULSE_LEN]);
    for (int k = 0; k < 7; k++)
    begin
      len = (mode_kind[k] == 2) ? w + 1 : (mode_kind[k] == 3) ? w - 1 : 4;
      src.idle(mode_idle[k]);
      apb(1'b1, tmc_pkg::IDX_SOURCE_SEL, mode_code[k]);
      apb(1'b1, tmc_pkg::IDX_TERMINATION, k % 2);
      rreg(tmc_pkg::IDX_SOURCE_SEL, 32'hFFFF_FFFF, model_reg[tmc_pkg::IDX_SOURCE_SEL]);
      chk("conn", {ext_input_en, trig_conn_oe, term_low_z}, {2'b10, k[0]});
      apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_START);
      repeat (tmc_pkg::SETUP_CYCLES + 8) @(posedge pclk);
      if (mode_kind[k] > 1)
        stim(k, w, 1'b1);
      stim(k, len, 1'b1);
      stim(k, len, 1'b0);
      finish_rec();
    end
    // Stop aborts setup
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_START);
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_STOP);
    rreg(tmc_pkg::IDX_STATUS, 32'h0000_000F, 32'h0000_0001);
    // Reset during setup restores defaults and idles the block
    apb(1'b1, tmc_pkg::IDX_COMMAND, tmc_pkg::CMD_START);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    model_reg[tmc_pkg::IDX_SOURCE_SEL] = tmc_pkg::RST_SOURCE_SEL;
    model_reg[tmc_pkg::IDX_PULSE_LEN]  = tmc_pkg::RST_PULSE_LEN;
    chk("reset out", {ext_input_en, trig_conn_oe, term_low_z, acq_start}, 4'h0);
    rreg(tmc_pkg::IDX_STATUS, 32'h0000_003F, 32'h0000_0001);
    rreg(tmc_pkg::IDX_SOURCE_SEL, 32'hFFFF_FFFF, model_reg[tmc_pkg::IDX_SOURCE_SEL]);
    rreg(tmc_pkg::IDX_PULSE_LEN, 32'h0000_00FF, model_reg[tmc_pkg::IDX_PULSE_LEN]);
    final_report();
  end
endmodule
